// File: common/flash_seq_pkg.sv
/*
  constants shared by the flash command sequencer and its host controller.
  assumes word addressing and 16-bit command data.
*/
package flash_seq_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BYPASS_ENTRY = 16'h0020;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  // program time, suspend latency and max accelerated ops in total
  localparam int CLK_MHZ = 125;
  localparam int PROG_TIME_NS = 800;
  localparam int PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ) / 1000;
  localparam int ACCEL_PROG_CYCLES = PROG_CYCLES / 4;
  localparam int SUSPEND_LAT_NS = 40;
  localparam int SUSPEND_LAT_CYCLES = (SUSPEND_LAT_NS * CLK_MHZ) / 1000;
  localparam int ACCEL_MAX_OPS = 10;
  localparam int SECTOR_SHIFT = 8;
  localparam int STAT_POLL_BIT = 7;
  localparam int STAT_TOGGLE_BIT = 6;
endpackage

// File: common/flash_cmd_if.sv
/*
  word-write and read channel between host controller and flash sequencer.
  assumes both ends share clock; accel pins are levels driven by the host.
*/
`timescale 1ns/10ps
`default_nettype none
interface flash_cmd_if;
  logic wr_stb;
  logic rd_stb;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic accel_voltage_input;
  logic accel_high_voltage_level;
  logic busy;
  modport device (
    input wr_stb, rd_stb, addr, wdata, accel_voltage_input, accel_high_voltage_level,
    output rdata, rvalid, busy
  );
  modport host (
    output wr_stb, rd_stb, addr, wdata, accel_voltage_input, accel_high_voltage_level,
    input rdata, rvalid, busy
  );
endinterface
`default_nettype wire

// File: core/pin_sync3.sv
/*
  three-stage synchroniser; output changes once stages two and three agree.
  assumes a single clock domain on the output side.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // level
  input wire logic din,
  output logic dout
);
  logic s1_q, s2_q, s3_q;
  // --------------------------------
  // shift and agree
  // --------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/flash_seq_device.sv
/*
  command sequencer of the flash: program suspend/resume, identifier read during program suspend,
  accelerated fast-program mode. array modelled as a small word memory.
  assumes the host keeps its own rules; accel pins arrive asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_seq_device #(
  parameter int DEPTH = 256,
  parameter int PROG_CYC = flash_seq_pkg::PROG_CYCLES,
  parameter int LAT_CYC = flash_seq_pkg::SUSPEND_LAT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link
  flash_cmd_if.device link,
  // user side: erase-suspend context and status
  input wire logic erase_suspended,
  input wire logic [3:0] erase_sector,
  output logic prog_suspended,
  output logic fast_mode,
  output logic accel_active
);
  typedef enum {ST_READ, ST_UNL1, ST_UNL2, ST_PSETUP, ST_PROG, ST_SUSP_PEND,
                ST_PSUSP, ST_AS_UNL1, ST_AS_UNL2, ST_AUTOSEL, ST_FSETUP,
                ST_FEXIT} state_t;
  state_t state_q, state_d;
  logic [15:0] mem [DEPTH];
  logic [11:0] paddr_q;
  logic [15:0] pdata_q;
  logic [15:0] cnt_q;
  logic fast_q, toggle_q, fast_prog_q;
  logic acc_low, acc_hv;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic done_q;
  logic hv_mode_q;
  logic busy_q;
  // --------------------------------
  // pin synchronisers
  // --------------------------------
  pin_sync3 u_acc (.clock(clock), .resetn(resetn), .din(link.accel_voltage_input),
                   .dout(acc_low));
  pin_sync3 u_hv (.clock(clock), .resetn(resetn), .din(link.accel_high_voltage_level),
                  .dout(acc_hv));
  // --------------------------------
  // decode
  // --------------------------------
  wire wr = link.wr_stb;
  wire [15:0] wd = link.wdata;
  wire [11:0] wa = link.addr;
  wire is_susp = wr && wd == flash_seq_pkg::CMD_SUSPEND;
  wire is_res = wr && wd == flash_seq_pkg::CMD_RESUME;
  wire unl1 = wr && wa == flash_seq_pkg::UNLOCK_ADDR1 && wd == flash_seq_pkg::CMD_UNLOCK1;
  wire unl2 = wr && wa == flash_seq_pkg::UNLOCK_ADDR2 && wd == flash_seq_pkg::CMD_UNLOCK2;
  wire at555 = wa == flash_seq_pkg::UNLOCK_ADDR1;
  wire locked = !acc_low;
  wire [3:0] rsec = 4'(link.addr >> flash_seq_pkg::SECTOR_SHIFT);
  wire [3:0] psec = 4'(paddr_q >> flash_seq_pkg::SECTOR_SHIFT);
  // in ST_PSUSP, suspended sectors read status, others read array data
  wire in_susp = rsec == psec || (erase_suspended && rsec == erase_sector);
  wire [11:0] prog_len = (fast_prog_q && acc_hv) ? 12'(PROG_CYC / 4) : 12'(PROG_CYC);
  wire [7:0] ma = link.addr[7:0];
  // --------------------------------
  // next state
  // --------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_READ: begin
        if (fast_q && wr && wd == flash_seq_pkg::CMD_PROGRAM) begin
          state_d = ST_FSETUP;
        end else if (fast_q && wr && wd == flash_seq_pkg::CMD_AUTOSEL) begin
          state_d = ST_FEXIT;
        end else if (!fast_q && unl1) begin
          state_d = ST_UNL1; // fast mode ignores everything else
        end
      end
      ST_UNL1: state_d = wr ? (unl2 ? ST_UNL2 : ST_READ) : ST_UNL1;
      ST_UNL2: begin
        if (wr && at555 && wd == flash_seq_pkg::CMD_PROGRAM) state_d = ST_PSETUP;
        else if (wr && at555 && wd == flash_seq_pkg::CMD_BYPASS_ENTRY) state_d = ST_READ;
        else if (wr) state_d = ST_READ;
      end
      ST_PSETUP, ST_FSETUP: if (wr) state_d = locked ? ST_READ : ST_PROG;
      ST_FEXIT: if (wr) state_d = ST_READ;
      ST_PROG: begin
        if (done_q) state_d = ST_READ;
        else if (is_susp) state_d = ST_SUSP_PEND;
      end
      ST_SUSP_PEND: if (cnt_q == 16'(LAT_CYC)) state_d = ST_PSUSP;
      ST_PSUSP: begin
        if (is_res) state_d = ST_PROG;
        else if (unl1) state_d = ST_AS_UNL1;
      end
      ST_AS_UNL1: state_d = wr ? (unl2 ? ST_AS_UNL2 : ST_PSUSP) : ST_AS_UNL1;
      ST_AS_UNL2: if (wr) state_d = (wd == flash_seq_pkg::CMD_AUTOSEL) ? ST_AUTOSEL : ST_PSUSP;
      ST_AUTOSEL: if (wr && wd == flash_seq_pkg::CMD_RESET) state_d = ST_PSUSP;
      default: state_d = ST_READ;
    endcase
  end
  // --------------------------------
  // state, mode and program timer
  // --------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_READ;
      fast_q <= 1'b0;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
      fast_prog_q <= 1'b0;
      hv_mode_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // removal of the high level closes the mode however it was opened; a mode entered by
      // the unlock words and never under the high level stays until the exit words arrive
      if (acc_hv) begin
        fast_q <= 1'b1;
        hv_mode_q <= 1'b1;
      end else if (hv_mode_q && state_q != ST_PROG && state_q != ST_SUSP_PEND) begin
        fast_q <= 1'b0; // wait for a running program to finish
        hv_mode_q <= 1'b0;
      end
      if (state_q == ST_UNL2 && wr && at555 && wd == flash_seq_pkg::CMD_BYPASS_ENTRY)
        fast_q <= 1'b1;
      if (state_q == ST_FEXIT && wr && wd == flash_seq_pkg::CMD_EXIT2 && !acc_hv)
        fast_q <= 1'b0;
      // a resume restarts the full program time: simpler, never shorter than needed
      if (state_q != state_d) cnt_q <= 16'h0000;
      else if (state_q == ST_PROG || state_q == ST_SUSP_PEND) cnt_q <= cnt_q + 16'h0001;
      done_q <= state_q == ST_PROG && cnt_q[11:0] >= prog_len - 12'h002;
      if (state_d == ST_PROG && state_q != ST_PSUSP) fast_prog_q <= fast_q;
    end
  end
  // --------------------------------
  // latch program target, write array on completion
  // --------------------------------
  always_ff @(posedge clock) begin
    if ((state_q == ST_PSETUP || state_q == ST_FSETUP) && wr) begin
      paddr_q <= wa;
      pdata_q <= wd;
    end
    if (done_q && state_q == ST_PROG) mem[paddr_q[7:0]] <= pdata_q;
  end
  // --------------------------------
  // read path with status bits
  // --------------------------------
  wire busy_st = state_q == ST_PROG || state_q == ST_SUSP_PEND;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      rvalid_q <= link.rd_stb;
      if (link.rd_stb) begin
        if (busy_st) begin
          toggle_q <= ~toggle_q;
          rdata_q <= 16'h0000;
          rdata_q[flash_seq_pkg::STAT_POLL_BIT] <= ~pdata_q[7];
          rdata_q[flash_seq_pkg::STAT_TOGGLE_BIT] <= ~toggle_q;
        end else if (state_q == ST_AUTOSEL) begin
          rdata_q <= {4'h0, link.addr}; // identifier codes, arbitrary
        end else if (state_q == ST_PSUSP && in_susp) begin
          rdata_q <= 16'h0080; // suspended status, poll bit high
        end else begin
          rdata_q <= mem[ma];
        end
      end
    end
  end
  // --------------------------------
  // outputs
  // --------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prog_suspended <= 1'b0;
      fast_mode <= 1'b0;
      accel_active <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      prog_suspended <= state_d == ST_PSUSP || state_d == ST_AS_UNL1 ||
                        state_d == ST_AS_UNL2 || state_d == ST_AUTOSEL;
      fast_mode <= fast_q;
      accel_active <= acc_hv;
      // registered from the next state, so it lines up with the state decode
      busy_q <= state_d == ST_PROG || state_d == ST_SUSP_PEND;
    end
  end
  assign link.rdata = rdata_q;
  assign link.rvalid = rvalid_q;
  assign link.busy = busy_q;
endmodule
`default_nettype wire

// File: core/flash_seq_host.sv
/*
  host controller end: turns user requests into flash command words.
  assumes the device answers reads one cycle after rd_stb.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_seq_host (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link
  flash_cmd_if.host link,
  // user requests (one-cycle pulses; accel_on is a level)
  input wire logic req_write,
  input wire logic [11:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic req_read,
  input wire logic req_suspend,
  input wire logic req_resume,
  input wire logic accel_on,
  // user answers
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [3:0] accel_ops
);
  logic wr_q, rd_q, acc_q, hv_q;
  logic [11:0] a_q;
  logic [15:0] d_q;
  // --------------------------------
  // one word per request; suspend and resume use address zero
  // --------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 12'h000;
      d_q <= 16'h0000;
      acc_q <= 1'b1; // idle high keeps sectors usable
      hv_q <= 1'b0;
      accel_ops <= 4'h0;
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      wr_q <= req_write || req_suspend || req_resume;
      rd_q <= req_read;
      if (req_suspend) begin
        a_q <= 12'h000;
        d_q <= flash_seq_pkg::CMD_SUSPEND;
      end else if (req_resume) begin
        a_q <= 12'h000;
        d_q <= flash_seq_pkg::CMD_RESUME;
      end else if (req_write || req_read) begin
        a_q <= req_addr;
        d_q <= req_data;
      end
      // cap accelerated operations
      hv_q <= accel_on && accel_ops < 4'(flash_seq_pkg::ACCEL_MAX_OPS);
      if (accel_on && !hv_q && accel_ops < 4'(flash_seq_pkg::ACCEL_MAX_OPS))
        accel_ops <= accel_ops + 4'h1;
      rd_valid <= link.rvalid;
      if (link.rvalid) rd_data <= link.rdata;
    end
  end
  assign link.wr_stb = wr_q;
  assign link.rd_stb = rd_q;
  assign link.addr = a_q;
  assign link.wdata = d_q;
  assign link.accel_voltage_input = acc_q;
  assign link.accel_high_voltage_level = hv_q;
endmodule
`default_nettype wire

// File: test/flash_link_asserts.sv
/*
  concurrent checks on the host to flash command channel.
  assumes one clock domain; sees only the interface signals.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_link_asserts #(
  parameter int PROG_CYC = 40,
  parameter int LAT_CYC = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // channel
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic accel_voltage_input,
  input wire logic accel_high_voltage_level,
  input wire logic busy
);
  localparam int SUS_MAX = LAT_CYC + 3;
  localparam int BUSY_MAX = PROG_CYC + LAT_CYC + 4;
  logic sus_q, prev_a0_q, tog_q, tog_v_q;
  logic [7:0] run_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // the suspended flag is not on the link, so it is rebuilt from the words
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sus_q <= 1'b0;
      prev_a0_q <= 1'b0;
      tog_q <= 1'b0;
      tog_v_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      if (wr_stb && wdata == flash_seq_pkg::CMD_SUSPEND && busy) begin
        sus_q <= 1'b1;
      end else if (wr_stb && wdata == flash_seq_pkg::CMD_RESUME) begin
        sus_q <= 1'b0;
      end
      if (wr_stb) begin
        prev_a0_q <= (wdata == flash_seq_pkg::CMD_PROGRAM);
      end
      if (rvalid) begin
        tog_q <= rdata[6];
        tog_v_q <= busy;
      end
      run_q <= busy ? run_q + 8'h01 : 8'h00; // wraps after 256 busy cycles, far above BUSY_MAX
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence sus_wr;
    wr_stb && wdata == flash_seq_pkg::CMD_SUSPEND && busy;
  endsequence
  a_read_answer: assert property (rd_stb |=> rvalid)
    else $error("read without answer");
  a_answer_cause: assert property (rvalid |-> $past(rd_stb))
    else $error("answer without read");
  a_prog_starts: assert property (wr_stb && prev_a0_q |-> ##[1:2] busy)
    else $error("program word did not start");
  a_busy_bounded: assert property (run_q <= BUSY_MAX)
    else $error("busy too long");
  a_suspend_halts: assert property (sus_wr |-> ##[1:SUS_MAX] !busy)
    else $error("suspend not honoured in time");
  a_resume_runs: assert property (wr_stb && wdata == flash_seq_pkg::CMD_RESUME
    && sus_q |-> ##[1:3] busy)
    else $error("resume did not restart");
  a_resume_ignored: assert property (wr_stb && wdata == flash_seq_pkg::CMD_RESUME
    && !sus_q && !busy && !prev_a0_q |=> !busy [*3])
    else $error("stray resume started work");
  a_toggle_flips: assert property (rvalid && busy && tog_v_q |-> rdata[6] != tog_q)
    else $error("toggle bit stuck while busy");
  a_accel_level: assert property (!accel_high_voltage_level |-> accel_voltage_input)
    else $error("accel input low outside acceleration");
endmodule
`default_nettype wire

// File: test/tb_top.sv
/*
  self-checking bench: host end and device end joined by the interface.
  assumes the host turns each request pulse into one link word.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int PROG_CYC = 40;
  localparam int LAT_CYC = 5;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req_write = 1'b0, req_read = 1'b0, req_suspend = 1'b0, req_resume = 1'b0;
  logic accel_on = 1'b0, erase_suspended = 1'b0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_data = 16'h0000;
  logic [3:0] erase_sector = 4'h0;
  logic [15:0] rd_data, got, t1;
  logic rd_valid, prog_suspended, fast_mode, accel_active;
  logic [3:0] accel_ops;
  int err_total = 0;
  int comparisons = 0;
  int n;
  flash_cmd_if lk ();
  flash_seq_host flash_seq_host_inst (.clock(clock), .resetn(resetn), .link(lk),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_read(req_read),
    .req_suspend(req_suspend), .req_resume(req_resume), .accel_on(accel_on),
    .rd_data(rd_data), .rd_valid(rd_valid), .accel_ops(accel_ops));
  flash_seq_device #(.PROG_CYC(PROG_CYC), .LAT_CYC(LAT_CYC)) flash_seq_device_inst (
    .clock(clock), .resetn(resetn), .link(lk), .erase_suspended(erase_suspended),
    .erase_sector(erase_sector), .prog_suspended(prog_suspended), .fast_mode(fast_mode),
    .accel_active(accel_active));
  flash_link_asserts #(.PROG_CYC(PROG_CYC), .LAT_CYC(LAT_CYC)) flash_link_asserts_inst (
    .clock(clock), .resetn(resetn), .wr_stb(lk.wr_stb), .rd_stb(lk.rd_stb), .addr(lk.addr),
    .wdata(lk.wdata), .rdata(lk.rdata), .rvalid(lk.rvalid), .busy(lk.busy),
    .accel_voltage_input(lk.accel_voltage_input),
    .accel_high_voltage_level(lk.accel_high_voltage_level));
  // free-running 125 MHz clock
  always #4 clock = ~clock;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  // inputs move on the falling edge so the rising edge sees them settled
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clock);
    req_write = 1'b1;
    req_addr = a;
    req_data = d;
    @(negedge clock);
    req_write = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    int i;
    @(negedge clock);
    req_read = 1'b1;
    req_addr = a;
    @(negedge clock);
    req_read = 1'b0;
    for (i = 0; i < 10 && rd_valid !== 1'b1; i++) @(negedge clock);
    chkb(rd_valid, 1'b1);
    d = rd_data;
  endtask
  task automatic pulse(input logic s);
    @(negedge clock);
    req_suspend = s;
    req_resume = !s;
    @(negedge clock);
    req_suspend = 1'b0;
    req_resume = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic unlock(input logic [15:0] c);
    wr(flash_seq_pkg::UNLOCK_ADDR1, flash_seq_pkg::CMD_UNLOCK1);
    wr(flash_seq_pkg::UNLOCK_ADDR2, flash_seq_pkg::CMD_UNLOCK2);
    wr(flash_seq_pkg::UNLOCK_ADDR1, c);
  endtask
  // bounded so a stuck busy ends the wait instead of the run
  task automatic wait_idle(output int c);
    c = 0;
    while (lk.busy !== 1'b0 && c < 400) begin
      @(negedge clock);
      c++;
    end
    chkb(c < 400, 1'b1);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    repeat (6) @(negedge clock);
    unlock(flash_seq_pkg::CMD_PROGRAM);
    wr(12'h105, 16'h1234);
    chkb(lk.busy, 1'b1);
    rd(12'h105, got);
    chkb(got[7], 1'b1);
    rd(12'h105, t1);
    chkb(got[6] ^ t1[6], 1'b1);
    wait_idle(n);
    rd(12'h105, got);
    chk(got, 16'h1234);
    pulse(1'b0);
    chkb(lk.busy, 1'b0);
    $display("test normal program done");
    erase_suspended = 1'b1;
    erase_sector = 4'h2;
    unlock(flash_seq_pkg::CMD_PROGRAM);
    wr(12'h333, 16'h5A5A);
    pulse(1'b1);
    repeat (LAT_CYC + 4) @(negedge clock);
    chkb(prog_suspended, 1'b1);
    chkb(lk.busy, 1'b0);
    rd(12'h105, got);
    chk(got, 16'h1234);
    rd(12'h333, got);
    chk(got, 16'h0080);
    unlock(flash_seq_pkg::CMD_AUTOSEL);
    rd(12'h345, got);
    chk(got, 16'h0345);
    wr(12'h000, flash_seq_pkg::CMD_RESET);
    chkb(prog_suspended, 1'b1);
    pulse(1'b0);
    chkb(prog_suspended, 1'b0);
    chkb(lk.busy, 1'b1);
    pulse(1'b0);
    chkb(prog_suspended, 1'b0);
    pulse(1'b1);
    repeat (LAT_CYC + 4) @(negedge clock);
    chkb(prog_suspended, 1'b1);
    pulse(1'b0);
    wait_idle(n);
    rd(12'h333, got);
    chk(got, 16'h5A5A);
    erase_suspended = 1'b0;
    $display("test suspend resume done");
    unlock(flash_seq_pkg::CMD_BYPASS_ENTRY);
    chkb(fast_mode, 1'b1);
    wr(flash_seq_pkg::UNLOCK_ADDR1, flash_seq_pkg::CMD_UNLOCK1);
    chkb(fast_mode, 1'b1);
    wr(12'h1C0, flash_seq_pkg::CMD_PROGRAM);
    wr(12'h1C0, 16'h0F0F);
    chkb(lk.busy, 1'b1);
    wait_idle(n);
    rd(12'h1C0, got);
    chk(got, 16'h0F0F);
    wr(12'h100, flash_seq_pkg::CMD_AUTOSEL);
    wr(12'h000, flash_seq_pkg::CMD_EXIT2);
    chkb(fast_mode, 1'b0);
    $display("test fast mode done");
    accel_on = 1'b1;
    repeat (8) @(negedge clock);
    chkb(accel_active, 1'b1);
    chkb(fast_mode, 1'b1);
    chk({12'h000, accel_ops}, 16'h0001);
    wr(12'h000, flash_seq_pkg::CMD_PROGRAM);
    wr(12'h1D0, 16'h7777);
    wait_idle(n);
    chkb(n <= PROG_CYC / 4, 1'b1);
    rd(12'h1D0, got);
    chk(got, 16'h7777);
    accel_on = 1'b0;
    repeat (8) @(negedge clock);
    chkb(accel_active, 1'b0);
    chkb(fast_mode, 1'b0);
    $display("test acceleration done");
    print_verdict();
  end
  // the tests need a few thousand ns; this leaves a wide margin
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
